/* File: design/acg_top.sv */
// converter channel gate, conversion sequencer and bus result registers
// assumes an analog converter that answers each start with one done pulse
`timescale 1ns/1ps
module acg_top #(
   parameter logic [6:0] TARGET_ADDR = acg_pkg::ACG_TARGET_ADDR
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // serial register bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // control from neighbouring registers
   input wire logic conv_enable,
   input wire logic bus_current_conv_off,
   input wire logic reg_reset_cmd,
   // analog converter
   output logic conv_start,
   output logic [3:0] conv_channel,
   input wire logic conv_done,
   input wire logic [15:0] conv_data,
   // results for channels held elsewhere
   output logic result_valid,
   output logic [3:0] result_channel,
   output logic [15:0] result_data
);
   import acg_pkg::*;

   // elaboration check: address zero is the general call
   if (TARGET_ADDR == 7'h00) begin : g_bad_target_addr
      $error("target address zero is the general call");
   end

   logic [7:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] channel_off_reg;
   logic [7:0] ibus_high;
   logic [7:0] ibus_low;
   logic [7:0] vbus_high;
   logic [7:0] vbus_low;
   acg_seq_t state;
   acg_seq_t next_state;
   logic [3:0] chan;
   logic [3:0] next_chan;

   acg_serial_target #(
      .TARGET_ADDR(TARGET_ADDR)
   ) u_serial (
      .clock(clock),
      .arst_n(arst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   // named disable bits
   wire bus_voltage_conv_off = channel_off_reg[ACG_BIT_BUS_VOLTAGE];
   wire adapter_voltage_conv_off = channel_off_reg[ACG_BIT_ADAPTER_VOLTAGE];
   wire output_voltage_conv_off = channel_off_reg[ACG_BIT_OUTPUT_VOLTAGE];
   wire battery_voltage_conv_off = channel_off_reg[ACG_BIT_BATTERY_VOLTAGE];
   wire battery_current_conv_off = channel_off_reg[ACG_BIT_BATTERY_CURRENT];
   wire bus_thermistor_conv_off = channel_off_reg[ACG_BIT_BUS_THERM];
   wire battery_thermistor_conv_off = channel_off_reg[ACG_BIT_BATTERY_THERM];
   wire die_temp_conv_off = channel_off_reg[ACG_BIT_DIE_TEMP];
   wire [8:0] skip_mask = {bus_current_conv_off,
                           bus_voltage_conv_off,
                           adapter_voltage_conv_off,
                           output_voltage_conv_off,
                           battery_voltage_conv_off,
                           battery_current_conv_off,
                           bus_thermistor_conv_off,
                           battery_thermistor_conv_off,
                           die_temp_conv_off};

   // register writes
   wire wr_channel_off = reg_wr && (reg_addr == ACG_ADDR_CHANNEL_OFF);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         channel_off_reg <= ACG_CHANNEL_OFF_RESET;
      end else if (reg_reset_cmd) begin
         channel_off_reg <= ACG_CHANNEL_OFF_RESET;
      end else if (wr_channel_off) begin
         channel_off_reg <= reg_wdata;
      end
   end

   // sequencer: walks channels 0..8, skipping disabled ones
   wire chan_skipped = skip_mask[chan];
   wire at_last = (chan == ACG_CHAN_LAST);
   wire [3:0] chan_after = at_last ? 4'h0 : chan + 4'h1;

   always_comb begin
      next_state = state;
      next_chan = chan;
      case (state)
         ACG_SEQ_IDLE: begin
            if (conv_enable) begin
               next_state = ACG_SEQ_PICK;
               next_chan = 4'h0;
            end
         end
         ACG_SEQ_PICK: begin
            if (!conv_enable) begin
               next_state = ACG_SEQ_IDLE;
            end else if (chan_skipped) begin
               next_chan = chan_after;
            end else begin
               next_state = ACG_SEQ_WAIT;
            end
         end
         ACG_SEQ_WAIT: begin
            if (conv_done) begin
               next_chan = chan_after;
               next_state = conv_enable ? ACG_SEQ_PICK : ACG_SEQ_IDLE;
            end
         end
         default: begin
            next_state = ACG_SEQ_IDLE;
         end
      endcase
   end

   wire start_now = (state == ACG_SEQ_PICK) && conv_enable && !chan_skipped;
   wire result_now = (state == ACG_SEQ_WAIT) && conv_done;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= ACG_SEQ_IDLE;
         chan <= 4'h0;
         conv_start <= 1'b0;
         conv_channel <= 4'h0;
      end else begin
         state <= next_state;
         chan <= next_chan;
         conv_start <= start_now;
         if (start_now) begin
            conv_channel <= chan;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         result_valid <= 1'b0;
         result_channel <= 4'h0;
         result_data <= ACG_RESULT_RESET;
      end else begin
         result_valid <= result_now;
         if (result_now) begin
            result_channel <= chan;
            result_data <= conv_data;
         end
      end
   end

   // results stored only on a finished conversion; only reset and register reset clear them
   wire load_ibus = result_now && (chan == ACG_CHAN_BUS_CURRENT);
   wire load_vbus = result_now && (chan == ACG_CHAN_BUS_VOLTAGE);

   acg_result_pair u_ibus (
      .clock(clock),
      .arst_n(arst_n),
      .clear(reg_reset_cmd),
      .load(load_ibus),
      .value(conv_data),
      .high_byte(ibus_high),
      .low_byte(ibus_low)
   );

   acg_result_pair u_vbus (
      .clock(clock),
      .arst_n(arst_n),
      .clear(reg_reset_cmd),
      .load(load_vbus),
      .value(conv_data),
      .high_byte(vbus_high),
      .low_byte(vbus_low)
   );

   // read decode
   wire rd_channel_off = (reg_addr == ACG_ADDR_CHANNEL_OFF);
   wire rd_ibus_high = (reg_addr == ACG_ADDR_IBUS_HIGH);
   wire rd_ibus_low = (reg_addr == ACG_ADDR_IBUS_LOW);
   wire rd_vbus_high = (reg_addr == ACG_ADDR_VBUS_HIGH);
   wire rd_vbus_low = (reg_addr == ACG_ADDR_VBUS_LOW);

   assign reg_rdata = rd_channel_off ? channel_off_reg :
                      rd_ibus_high ? ibus_high :
                      rd_ibus_low ? ibus_low :
                      rd_vbus_high ? vbus_high :
                      rd_vbus_low ? vbus_low :
                      ACG_UNMAPPED_READ;
endmodule : acg_top

/* File: design/acg_pkg.sv */
// constants for the converter channel gate and result registers
// assumes a byte-wide register space reached over a two-wire serial bus
package acg_pkg;
   // register byte addresses
   localparam logic [7:0] ACG_ADDR_CHANNEL_OFF = 8'h15;
   localparam logic [7:0] ACG_ADDR_IBUS_HIGH = 8'h16;
   localparam logic [7:0] ACG_ADDR_IBUS_LOW = 8'h17;
   localparam logic [7:0] ACG_ADDR_VBUS_HIGH = 8'h18;
   localparam logic [7:0] ACG_ADDR_VBUS_LOW = 8'h19;
   // reset values; results have no defined value, zero is used
   localparam logic [7:0] ACG_CHANNEL_OFF_RESET = 8'h00;
   localparam logic [15:0] ACG_RESULT_RESET = 16'h0000;
   localparam logic [7:0] ACG_UNMAPPED_READ = 8'h00;
   // channel-disable bit positions, also the sequencer channel codes
   localparam int ACG_BIT_DIE_TEMP = 0;
   localparam int ACG_BIT_BATTERY_THERM = 1;
   localparam int ACG_BIT_BUS_THERM = 2;
   localparam int ACG_BIT_BATTERY_CURRENT = 3;
   localparam int ACG_BIT_BATTERY_VOLTAGE = 4;
   localparam int ACG_BIT_OUTPUT_VOLTAGE = 5;
   localparam int ACG_BIT_ADAPTER_VOLTAGE = 6;
   localparam int ACG_BIT_BUS_VOLTAGE = 7;
   localparam logic [3:0] ACG_CHAN_BUS_CURRENT = 4'h8;
   localparam logic [3:0] ACG_CHAN_LAST = 4'h8;
   localparam logic [3:0] ACG_CHAN_BUS_VOLTAGE = 4'h7;
   // result layout: sign in bit 15, magnitude in bits 14:0
   localparam int ACG_SIGN_BIT = 15;
   // default serial target address, arbitrary
   localparam logic [6:0] ACG_TARGET_ADDR = 7'h6a;

   typedef enum logic [1:0] {
      ACG_SEQ_IDLE = 2'b00,
      ACG_SEQ_PICK = 2'b01,
      ACG_SEQ_WAIT = 2'b10
   } acg_seq_t;

   typedef enum logic [3:0] {
      ACG_SER_IDLE = 4'b0000,
      ACG_SER_ADDR = 4'b0001,
      ACG_SER_ADDR_ACK = 4'b0010,
      ACG_SER_PTR = 4'b0011,
      ACG_SER_PTR_ACK = 4'b0100,
      ACG_SER_WDATA = 4'b0101,
      ACG_SER_WDATA_ACK = 4'b0110,
      ACG_SER_RDATA = 4'b0111,
      ACG_SER_RDATA_ACK = 4'b1000
   } acg_ser_t;
endpackage : acg_pkg

/* File: design/acg_result_pair.sv */
// one signed 16-bit conversion result split into high and low bytes
// assumes load is a one-cycle pulse from the sequencer and clear one from the register reset command
`timescale 1ns/1ps
module acg_result_pair (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // update side
   input wire logic clear,
   input wire logic load,
   input wire logic [15:0] value,
   // register view
   output logic [7:0] high_byte,
   output logic [7:0] low_byte
);
   import acg_pkg::*;

   logic [15:0] result;

   // clear wins: register reset discards a result in flight
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         result <= ACG_RESULT_RESET;
      end else if (clear) begin
         result <= ACG_RESULT_RESET;
      end else if (load) begin
         result <= value;
      end
   end

   // sign sits in bit 7 of the high byte
   assign high_byte = result[15:8];
   assign low_byte = result[7:0];
endmodule : acg_result_pair

/* File: design/acg_serial_target.sv */
// two-wire serial target: pointer write, data writes, data reads
// assumes scl and sda are already synchronous to clock
`timescale 1ns/1ps
module acg_serial_target #(
   parameter logic [6:0] TARGET_ADDR = acg_pkg::ACG_TARGET_ADDR
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // register access
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   import acg_pkg::*;

   acg_ser_t state;
   logic scl_q;
   logic sda_q;
   logic [2:0] bit_cnt;
   logic full;
   logic [7:0] shift;
   logic read_mode;
   logic nack;

   wire start_seen = scl_in & scl_q & sda_q & ~sda_in;
   wire stop_seen = scl_in & scl_q & ~sda_q & sda_in;
   wire scl_rise = scl_in & ~scl_q;
   wire scl_fall = ~scl_in & scl_q;
   wire addr_match = (shift[7:1] == TARGET_ADDR);
   wire collecting = (state == ACG_SER_ADDR) || (state == ACG_SER_PTR) ||
                     (state == ACG_SER_WDATA) || (state == ACG_SER_RDATA);

   assign sda_out = 1'b0;
   assign reg_wdata = shift;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= ACG_SER_IDLE;
         bit_cnt <= 3'h0;
         full <= 1'b0;
         shift <= 8'h00;
         read_mode <= 1'b0;
         nack <= 1'b0;
         sda_oe <= 1'b0;
         reg_addr <= 8'h00;
         reg_wr <= 1'b0;
      end else begin
         reg_wr <= 1'b0;
         if (start_seen) begin
            state <= ACG_SER_ADDR;
            bit_cnt <= 3'h0;
            full <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_seen) begin
            state <= ACG_SER_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            if (collecting) begin
               if (state != ACG_SER_RDATA) begin
                  shift <= {shift[6:0], sda_in};
               end
               bit_cnt <= bit_cnt + 3'h1;
               full <= (bit_cnt == 3'h7);
            end
            if (state == ACG_SER_RDATA_ACK) begin
               nack <= sda_in;
            end
         end else if (scl_fall) begin
            case (state)
               ACG_SER_ADDR: begin
                  if (full && addr_match) begin
                     read_mode <= shift[0];
                     sda_oe <= 1'b1;
                     state <= ACG_SER_ADDR_ACK;
                  end else if (full) begin
                     state <= ACG_SER_IDLE;
                  end
               end
               ACG_SER_ADDR_ACK: begin
                  full <= 1'b0;
                  if (read_mode) begin
                     shift <= reg_rdata;
                     sda_oe <= ~reg_rdata[7];
                     reg_addr <= reg_addr + 8'h01;
                     state <= ACG_SER_RDATA;
                  end else begin
                     sda_oe <= 1'b0;
                     state <= ACG_SER_PTR;
                  end
               end
               ACG_SER_PTR: begin
                  if (full) begin
                     reg_addr <= shift;
                     sda_oe <= 1'b1;
                     state <= ACG_SER_PTR_ACK;
                  end
               end
               ACG_SER_WDATA: begin
                  if (full) begin
                     reg_wr <= 1'b1;
                     sda_oe <= 1'b1;
                     state <= ACG_SER_WDATA_ACK;
                  end
               end
               ACG_SER_PTR_ACK, ACG_SER_WDATA_ACK: begin
                  if (state == ACG_SER_WDATA_ACK) begin
                     reg_addr <= reg_addr + 8'h01;
                  end
                  full <= 1'b0;
                  sda_oe <= 1'b0;
                  state <= ACG_SER_WDATA;
               end
               ACG_SER_RDATA: begin
                  if (full) begin
                     sda_oe <= 1'b0;
                     state <= ACG_SER_RDATA_ACK;
                  end else begin
                     shift <= {shift[6:0], 1'b0};
                     sda_oe <= ~shift[6];
                  end
               end
               ACG_SER_RDATA_ACK: begin
                  full <= 1'b0;
                  if (nack) begin
                     state <= ACG_SER_IDLE;
                  end else begin
                     shift <= reg_rdata;
                     sda_oe <= ~reg_rdata[7];
                     reg_addr <= reg_addr + 8'h01;
                     state <= ACG_SER_RDATA;
                  end
               end
               default: begin
                  state <= ACG_SER_IDLE;
               end
            endcase
         end
      end
   end
endmodule : acg_serial_target

/* File: verification/acg_host_model.sv */
// host model: drives the serial clock and the open-drain data line
// assumes the target samples both lines on each rising clock edge
`timescale 1ns/1ps
module acg_host_model (
   // clock
   input wire logic clock,
   // target drive of the data line
   input wire logic sda_out,
   input wire logic sda_oe,
   // wire levels seen by the target
   output logic scl_in,
   output logic sda_in
);
   logic host_low;
   // pull-up: high unless a party pulls low
   assign sda_in = !(host_low || (sda_oe && !sda_out));
   initial begin
      scl_in = 1'b1;
      host_low = 1'b0;
   end
   // third of a bit, above the three-clock phase minimum
   task automatic wt;
      repeat (4) @(negedge clock);
   endtask : wt
   // b = 1 releases the line, s is the level at the end of scl high
   task automatic clk_bit(input logic b, output logic s);
      wt();
      host_low = !b;
      wt();
      scl_in = 1'b1;
      wt();
      s = sda_in;
      scl_in = 1'b0;
   endtask : clk_bit
   task automatic start;
      wt();
      host_low = 1'b0;
      wt();
      scl_in = 1'b1;
      wt();
      host_low = 1'b1;
      wt();
      scl_in = 1'b0;
   endtask : start
   task automatic stop;
      wt();
      host_low = 1'b1;
      wt();
      scl_in = 1'b1;
      wt();
      host_low = 1'b0;
   endtask : stop
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
      clk_bit(1'b1, s);
      ack = !s;
   endtask : send
   // single byte read, ended by a nack
   task automatic recv(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b1, s);
   endtask : recv
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                            input logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start();
      send({dev, 1'b0}, k0);
      send(a, k1);
      send(d, k2);
      stop();
      ok = k0 && k1 && k2;
   endtask : write_reg
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] a,
                           output logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start();
      send({dev, 1'b0}, k0);
      send(a, k1);
      start();
      send({dev, 1'b1}, k2);
      recv(d);
      stop();
      ok = k0 && k1 && k2;
   endtask : read_reg
endmodule : acg_host_model

/* File: verification/acg_top_props.sv */
// checker for the channel gate and result block
// assumes the converter answers only while a conversion is open
`timescale 1ns/1ps
module acg_top_props
   import acg_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_oe,
   // control
   input wire logic conv_enable,
   input wire logic bus_current_conv_off,
   // converter
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic conv_done,
   input wire logic [15:0] conv_data,
   // results
   input wire logic result_valid,
   input wire logic [3:0] result_channel,
   input wire logic [15:0] result_data
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   property p_start_en; conv_start |-> $past(conv_enable); endproperty
   a_start_en: assert property (p_start_en)
      else $error("start while converter disabled");
   property p_start_pulse; conv_start |=> !conv_start; endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start longer than one cycle");
   property p_chan; conv_start |-> conv_channel <= ACG_CHAN_LAST; endproperty
   a_chan: assert property (p_chan)
      else $error("channel code out of range");
   property p_ibus_gate;
      conv_start && conv_channel == ACG_CHAN_BUS_CURRENT
         |-> !$past(bus_current_conv_off);
   endproperty
   a_ibus_gate: assert property (p_ibus_gate)
      else $error("disabled bus current converted");
   property p_result;
      conv_done |=> result_valid && result_data == $past(conv_data)
         && result_channel == $past(conv_channel);
   endproperty
   a_result: assert property (p_result)
      else $error("result not passed on");
   property p_cause; result_valid |-> $past(conv_done); endproperty
   a_cause: assert property (p_cause)
      else $error("result without conversion");
   property p_sign;
      result_valid |-> result_data[ACG_SIGN_BIT] == $past(conv_data[15]);
   endproperty
   a_sign: assert property (p_sign)
      else $error("sign bit wrong");
   property p_oe_low; $rose(sda_oe) |-> !scl_in; endproperty
   a_oe_low: assert property (p_oe_low)
      else $error("data driven while scl high");
   c_ibus: cover property (conv_start && conv_channel == 4'h8);
   c_vbus: cover property (result_valid && result_channel == 4'h7);
   c_ack: cover property ($rose(sda_oe));
endmodule : acg_top_props

bind acg_top acg_top_props acg_top_props_inst (
   .clock(clock), .arst_n(arst_n), .scl_in(scl_in), .sda_oe(sda_oe),
   .conv_enable(conv_enable), .bus_current_conv_off(bus_current_conv_off),
   .conv_start(conv_start), .conv_channel(conv_channel),
   .conv_done(conv_done), .conv_data(conv_data),
   .result_valid(result_valid), .result_channel(result_channel),
   .result_data(result_data));

/* File: verification/acg_top_tb.sv */
// testbench for the channel gate and result block
// assumes the host model and a simple converter model in the bench
`timescale 1ns/1ps
module acg_top_tb;
   import acg_pkg::*;
   logic clock, arst_n, scl_in, sda_in, sda_out, sda_oe;
   logic conv_enable, bus_current_conv_off, reg_reset_cmd;
   logic conv_start, conv_done, result_valid;
   logic [3:0] conv_channel, result_channel;
   logic [15:0] conv_data, result_data;
   logic [15:0] conv_value [0:8] = '{default: 16'h0};
   logic [8:0] seen;
   int n_errors = 0;
   int samples_checked = 0;

   acg_top acg_top_inst (.clock(clock), .arst_n(arst_n), .scl_in(scl_in),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .conv_enable(conv_enable), .reg_reset_cmd(reg_reset_cmd),
      .bus_current_conv_off(bus_current_conv_off),
      .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_done(conv_done), .conv_data(conv_data),
      .result_valid(result_valid), .result_channel(result_channel),
      .result_data(result_data));
   acg_host_model acg_host_model_inst (.clock(clock), .sda_out(sda_out),
      .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // converter: answers each start three cycles later
   initial begin
      conv_done = 1'b0;
      conv_data = 16'h0;
      forever begin
         @(posedge clock iff conv_start === 1'b1);
         seen[conv_channel] = 1'b1;
         repeat (3) @(negedge clock);
         conv_data = conv_value[conv_channel];
         conv_done = 1'b1;
         @(negedge clock);
         conv_done = 1'b0;
         conv_data = ~conv_data;
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      acg_host_model_inst.read_reg(ACG_TARGET_ADDR, a, d, ok);
      check({7'h0, ok, d}, {8'h01, e});
   endtask : rd_chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      acg_host_model_inst.write_reg(ACG_TARGET_ADDR, a, d, ok);
      check({15'h0, ok}, 16'h1);
   endtask : wr
   task automatic run_conv(input logic [7:0] dis, input logic ib_off);
      wr(ACG_ADDR_CHANNEL_OFF, dis);
      bus_current_conv_off = ib_off;
      seen = '0;
      conv_enable = 1'b1;
      repeat (300) @(negedge clock);
      conv_enable = 1'b0;
      repeat (20) @(negedge clock);
   endtask : run_conv
   task automatic rd_res(input logic [15:0] iv, input logic [15:0] vv);
      rd_chk(ACG_ADDR_IBUS_HIGH, iv[15:8]);
      rd_chk(ACG_ADDR_IBUS_LOW, iv[7:0]);
      rd_chk(ACG_ADDR_VBUS_HIGH, vv[15:8]);
      rd_chk(ACG_ADDR_VBUS_LOW, vv[7:0]);
   endtask : rd_res
   task automatic t_regs;
      logic ok;
      rd_chk(ACG_ADDR_CHANNEL_OFF, 8'h00);
      rd_res(16'h0, 16'h0);
      wr(ACG_ADDR_IBUS_HIGH, 8'h5a);
      rd_chk(ACG_ADDR_IBUS_HIGH, 8'h00);
      rd_chk(8'h40, ACG_UNMAPPED_READ);
      wr(ACG_ADDR_CHANNEL_OFF, 8'ha5);
      acg_host_model_inst.write_reg(ACG_TARGET_ADDR ^ 7'h01,
                                    ACG_ADDR_CHANNEL_OFF, 8'h3c, ok);
      check({15'h0, ok}, 16'h0);
      rd_chk(ACG_ADDR_CHANNEL_OFF, 8'ha5);
      $display("test regs done");
   endtask : t_regs
   task automatic t_gating;
      logic [7:0] pat [3] = '{8'h00, 8'h5a, 8'hff};
      for (int i = 0; i < 3; i++) begin
         run_conv(pat[i], pat[i][0]);
         check({7'h0, seen}, {7'h0, ~pat[i][0], ~pat[i]});
      end
      $display("test gating done");
   endtask : t_gating
   task automatic t_results;
      logic [15:0] iv [2] = '{16'h8123, 16'h7ffe};
      logic [15:0] vv [2] = '{16'h7f01, 16'hfffe};
      for (int i = 0; i < 2; i++) begin
         conv_value[8] = iv[i];
         conv_value[7] = vv[i];
         run_conv(8'h7f, 1'b0);
         rd_res(iv[i], vv[i]);
      end
      conv_value[8] = 16'h1111;
      conv_value[7] = 16'h2222;
      run_conv(8'h80, 1'b1);
      check({7'h0, seen}, 16'h007f);
      rd_res(iv[1], vv[1]);
      $display("test results done");
   endtask : t_results
   task automatic t_reg_reset;
      wr(ACG_ADDR_CHANNEL_OFF, 8'hc3);
      reg_reset_cmd = 1'b1;
      @(negedge clock);
      reg_reset_cmd = 1'b0;
      rd_chk(ACG_ADDR_CHANNEL_OFF, 8'h00);
      rd_res(16'h0, 16'h0);
      $display("test reg_reset done");
   endtask : t_reg_reset
   task automatic test_done;
      $display("%0d checked, %0d errors", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   initial begin
      arst_n = 1'b0;
      conv_enable = 1'b0;
      bus_current_conv_off = 1'b0;
      reg_reset_cmd = 1'b0;
      repeat (20) @(negedge clock);
      arst_n = 1'b1;
      repeat (4) @(negedge clock);
      t_regs();
      t_gating();
      t_results();
      t_reg_reset();
      test_done();
   end
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      test_done();
   end
endmodule : acg_top_tb
